// *** logic/text_placement_pkg.sv ***
// constants, register map and carrier types for the text placement engine
// assumes a 125 MHz core clock and a 240 x 64 pixel screen behind a drawing unit
package text_placement_pkg;
   // ----------------------------------------------------------------
   // command stream
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_PREFIX = 8'hfe;
   localparam logic [7:0] CMD_CELL_POS = 8'h47;
   localparam logic [7:0] CMD_HOME = 8'h48;
   localparam logic [7:0] CMD_SCROLL_ON = 8'h51;
   localparam logic [7:0] CMD_SCROLL_OFF = 8'h52;
   localparam logic [7:0] CMD_PIXEL_POS = 8'h79;
   localparam logic [7:0] CMD_GLYPH_SET = 8'h31;
   localparam logic [7:0] CMD_METRICS = 8'h32;
   localparam int BMP_BITS = 8;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_SCROLL_ROW = 8'h40;
   localparam logic [7:0] RST_GLYPH_SET = 8'h01;
   localparam logic RST_AUTO_SCROLL = 1'b1;
   localparam logic [7:0] RST_MARGIN = 8'h00;
   localparam logic [7:0] RST_GAP = 8'h01;
   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_POS = 8'h04;
   localparam logic [7:0] REG_METRICS = 8'h08;
   localparam logic [7:0] REG_SCROLL = 8'h0c;
   localparam logic [7:0] REG_GLYPH_SET = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] left;
      logic [7:0] top;
      logic [7:0] hgap;
      logic [7:0] vgap;
      logic [7:0] scroll_row;
   } metrics_t;
   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
      logic [7:0] code;
      logic [7:0] glyph_set_index;
   } draw_t;
   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
      logic on;
   } pixel_t;
   // parameter bytes that follow each command code
   function automatic logic [2:0] param_count(input logic [7:0] code);
      unique case (code)
         CMD_CELL_POS, CMD_PIXEL_POS: param_count = 3'd2;
         CMD_GLYPH_SET: param_count = 3'd1;
         CMD_METRICS: param_count = 3'd5;
         default: param_count = 3'd0;
      endcase
   endfunction
endpackage

// *** logic/text_placement_engine.sv ***
// text placement engine: byte stream interpreter, insertion point, bitmap unpacker
// assumes a glyph store answering glyph_present/width/height for glyph_code within one cycle,
// a drawing unit with valid/ready, and an AXI4-Lite master on the register side
`timescale 1ns/100ps

module text_placement_engine #(
   parameter int SCREEN_W = 240
) (
   input wire logic core_clk,
   input wire logic nrst,
   // byte stream from the host link
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   // glyph store
   output logic [7:0] glyph_code,
   output logic [7:0] glyph_set_index,
   input wire logic glyph_present,
   input wire logic [7:0] glyph_width,
   input wire logic [7:0] glyph_height,
   input wire logic [7:0] glyph_widest,
   // drawing unit
   output logic draw_valid,
   output text_placement_pkg::draw_t draw,
   input wire logic draw_ready,
   output logic scroll_valid,
   output logic [7:0] scroll_lines,
   // bitmap bytes to pixels
   input wire logic bmp_start,
   input wire logic bmp_stored,
   input wire logic [7:0] bmp_x0,
   input wire logic [7:0] bmp_y0,
   input wire logic [7:0] bmp_height,
   input wire logic [7:0] bmp_width,
   input wire logic bmp_valid,
   input wire logic [7:0] bmp_byte,
   output logic bmp_ready,
   output logic pix_valid,
   output text_placement_pkg::pixel_t pix,
   // AXI4-Lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   import text_placement_pkg::*;

   initial begin
      if (SCREEN_W < 8 || SCREEN_W > 255) $error("SCREEN_W must lie in 8..255");
   end

   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_PARAM, ST_EXEC, ST_GLYPH, ST_DRAW} state_t;

   state_t state;
   logic [7:0] cmd;
   logic [7:0] prm [5];
   logic [2:0] prm_idx;
   logic [2:0] prm_left;
   logic [7:0] pos_x;
   logic [7:0] pos_y;
   logic auto_scroll;
   metrics_t metrics;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic sw_we;

   // ----------------------------------------------------------------
   // stream interpreter
   // ----------------------------------------------------------------
   // rx_ready is low outside the collecting states so a glyph or command is finished first
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         cmd <= 8'h00;
         prm_idx <= 3'd0;
         prm_left <= 3'd0;
         glyph_code <= 8'h00;
         rx_ready <= 1'b0;
         for (int i = 0; i < 5; i++) prm[i] <= 8'h00;
      end else begin
         unique case (state)
            ST_IDLE: begin
               rx_ready <= 1'b1;
               if (rx_valid && rx_ready) begin
                  if (rx_data == CMD_PREFIX) begin
                     state <= ST_CMD;
                  end else begin
                     glyph_code <= rx_data;
                     rx_ready <= 1'b0;
                     state <= ST_GLYPH;
                  end
               end
            end
            ST_CMD: begin
               if (rx_valid && rx_ready) begin
                  cmd <= rx_data;
                  prm_idx <= 3'd0;
                  prm_left <= param_count(rx_data);
                  if (param_count(rx_data) == 3'd0) begin
                     rx_ready <= 1'b0;
                     state <= ST_EXEC;
                  end else begin
                     state <= ST_PARAM;
                  end
               end
            end
            ST_PARAM: begin
               if (rx_valid && rx_ready) begin
                  prm[prm_idx] <= rx_data;
                  prm_idx <= prm_idx + 3'd1;
                  prm_left <= prm_left - 3'd1;
                  if (prm_left == 3'd1) begin
                     rx_ready <= 1'b0;
                     state <= ST_EXEC;
                  end
               end
            end
            ST_EXEC: begin
               rx_ready <= 1'b1;
               state <= ST_IDLE;
            end
            ST_GLYPH: begin
               // undefined code: nothing drawn, point untouched
               state <= glyph_present ? ST_DRAW : ST_IDLE;
               rx_ready <= !glyph_present;
            end
            ST_DRAW: begin
               if (draw_ready) begin
                  rx_ready <= 1'b1;
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // insertion point and glyph placement
   // ----------------------------------------------------------------
   // a glyph that would cross the right edge starts a new row; a row below the
   // scroll row either scrolls the image or wraps to the text area top
   always_ff @(posedge core_clk or negedge nrst) begin
      logic [9:0] px;
      logic [9:0] py;
      logic [9:0] pitch;
      if (!nrst) begin
         pos_x <= RST_MARGIN;
         pos_y <= RST_MARGIN;
         draw_valid <= 1'b0;
         draw <= '0;
         scroll_valid <= 1'b0;
         scroll_lines <= 8'h00;
      end else if (state == ST_EXEC) begin
         unique case (cmd)
            CMD_CELL_POS: begin
               pos_x <= 8'(glyph_widest * prm[0]);
               pos_y <= 8'(glyph_height * (prm[1] + metrics.vgap));
            end
            CMD_HOME: begin
               pos_x <= metrics.left;
               pos_y <= metrics.top;
            end
            CMD_PIXEL_POS: begin
               pos_x <= prm[0];
               pos_y <= prm[1];
            end
            default: begin
            end
         endcase
      end else if (state == ST_GLYPH && glyph_present) begin
         // widened copies so the edge and scroll tests cannot wrap around
         px = {2'b00, pos_x};
         py = {2'b00, pos_y};
         pitch = 10'(glyph_height) + 10'(metrics.vgap);
         if (px + 10'(glyph_width) > 10'(SCREEN_W)) begin
            px = 10'(metrics.left);
            py = py + pitch;
         end
         scroll_valid <= 1'b0;
         if (py + 10'(glyph_height) > 10'(metrics.scroll_row)) begin
            if (auto_scroll) begin
               scroll_valid <= 1'b1;
               scroll_lines <= 8'(pitch);
               py = py - pitch;
            end else begin
               px = 10'(metrics.left);
               py = 10'(metrics.top);
            end
         end
         draw_valid <= 1'b1;
         draw <= '{x: 8'(px), y: 8'(py), code: glyph_code, glyph_set_index: glyph_set_index};
         pos_x <= 8'(px + 10'(glyph_width) + 10'(metrics.hgap));
         pos_y <= 8'(py);
      end else if (state == ST_DRAW && draw_ready) begin
         draw_valid <= 1'b0;
         scroll_valid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // settings written by commands or by software
   // ----------------------------------------------------------------
   // a command executing in the same cycle as a software write wins
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         auto_scroll <= RST_AUTO_SCROLL;
         metrics <= '{RST_MARGIN, RST_MARGIN, RST_GAP, RST_GAP, RST_SCROLL_ROW};
         glyph_set_index <= RST_GLYPH_SET;
      end else if (state == ST_EXEC) begin
         unique case (cmd)
            CMD_SCROLL_ON: auto_scroll <= 1'b1;
            CMD_SCROLL_OFF: auto_scroll <= 1'b0;
            CMD_GLYPH_SET: glyph_set_index <= prm[0];
            CMD_METRICS: metrics <= '{prm[0], prm[1], prm[2], prm[3], prm[4]};
            default: begin
            end
         endcase
      end else if (sw_we) begin
         if (aw_addr == REG_CTRL && w_strb[0]) auto_scroll <= w_data[0];
         if (aw_addr == REG_METRICS) begin
            if (w_strb[3]) metrics.left <= w_data[31:24];
            if (w_strb[2]) metrics.top <= w_data[23:16];
            if (w_strb[1]) metrics.hgap <= w_data[15:8];
            if (w_strb[0]) metrics.vgap <= w_data[7:0];
         end
         if (aw_addr == REG_SCROLL && w_strb[0]) metrics.scroll_row <= w_data[7:0];
         if (aw_addr == REG_GLYPH_SET && w_strb[0]) glyph_set_index <= w_data[7:0];
      end
   end

   // ----------------------------------------------------------------
   // bitmap unpacker, one pixel per cycle
   // ----------------------------------------------------------------
   logic [7:0] bmp_sh;
   logic [3:0] bmp_left;
   logic bmp_mode;
   logic [7:0] cur_x;
   logic [7:0] cur_y;
   logic [7:0] org_x;
   logic [7:0] org_y;
   logic [7:0] bmp_h;
   logic [7:0] bmp_w;
   // stored images run down a column and carry leftover bits into the next column;
   // inline images run across a row, MSB first
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bmp_sh <= 8'h00;
         bmp_left <= 4'd0;
         bmp_mode <= 1'b0;
         cur_x <= 8'h00;
         cur_y <= 8'h00;
         org_x <= 8'h00;
         org_y <= 8'h00;
         bmp_h <= 8'h01;
         bmp_w <= 8'h01;
         bmp_ready <= 1'b0;
         pix_valid <= 1'b0;
         pix <= '0;
      end else if (bmp_start) begin
         bmp_mode <= bmp_stored;
         org_x <= bmp_x0;
         org_y <= bmp_y0;
         cur_x <= bmp_x0;
         cur_y <= bmp_y0;
         bmp_h <= (bmp_height == 8'h00) ? 8'h01 : bmp_height;
         bmp_w <= (bmp_width == 8'h00) ? 8'h01 : bmp_width;
         bmp_left <= 4'd0;
         bmp_ready <= 1'b1;
         pix_valid <= 1'b0;
      end else if (bmp_left == 4'd0) begin
         pix_valid <= 1'b0;
         if (bmp_valid && bmp_ready) begin
            bmp_sh <= bmp_byte;
            bmp_left <= 4'(BMP_BITS);
            bmp_ready <= 1'b0;
         end
      end else begin
         pix_valid <= 1'b1;
         pix.x <= cur_x;
         pix.y <= cur_y;
         if (bmp_mode) begin
            pix.on <= bmp_sh[0];
            bmp_sh <= {1'b0, bmp_sh[7:1]};
            if (cur_y - org_y == bmp_h - 8'h01) begin
               cur_y <= org_y;
               cur_x <= cur_x + 8'h01;
            end else begin
               cur_y <= cur_y + 8'h01;
            end
         end else begin
            pix.on <= bmp_sh[7];
            bmp_sh <= {bmp_sh[6:0], 1'b0};
            if (cur_x - org_x == bmp_w - 8'h01) begin
               cur_x <= org_x;
               cur_y <= cur_y + 8'h01;
            end else begin
               cur_x <= cur_x + 8'h01;
            end
         end
         bmp_left <= bmp_left - 4'd1;
         bmp_ready <= (bmp_left == 4'd1);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   assign sw_we = aw_held && w_held && !s_bvalid;
   // address and data may arrive in either order; each is held until both are present
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
      end else begin
         s_awready <= !aw_held && !(s_awvalid && s_awready);
         s_wready <= !w_held && !(s_wvalid && s_wready);
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
         end
         if (sw_we) begin
            s_bvalid <= 1'b1;
            s_bresp <= (aw_addr == REG_CTRL || aw_addr == REG_METRICS || aw_addr == REG_SCROLL ||
                        aw_addr == REG_GLYPH_SET) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   // reads show the live insertion point and settings
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= RESP_OKAY;
      end else if (s_rvalid) begin
         if (s_rready) s_rvalid <= 1'b0;
         s_arready <= s_rready;
      end else begin
         s_arready <= !(s_arvalid && s_arready);
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp <= RESP_OKAY;
            unique case (s_araddr)
               REG_CTRL: s_rdata <= {31'h0, auto_scroll};
               REG_POS: s_rdata <= {16'h0000, pos_y, pos_x};
               REG_METRICS: s_rdata <= {metrics.left, metrics.top, metrics.hgap, metrics.vgap};
               REG_SCROLL: s_rdata <= {24'h000000, metrics.scroll_row};
               REG_GLYPH_SET: s_rdata <= {24'h000000, glyph_set_index};
               default: begin
                  s_rdata <= 32'h0000_0000;
                  s_rresp <= RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence seq_exec(logic [7:0] code);
      state == ST_EXEC && cmd == code;
   endsequence
   sequence seq_text_byte;
      state == ST_IDLE && rx_valid && rx_ready && rx_data != CMD_PREFIX;
   endsequence

   a_text_starts_glyph: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_text_byte |=> state == ST_GLYPH && glyph_code == $past(rx_data))
      else $error("text byte did not start a glyph");
   a_missing_glyph_drop: assert property (@(posedge core_clk) disable iff (!nrst)
      state == ST_GLYPH && !glyph_present |=> !draw_valid && $stable(pos_x) && $stable(pos_y))
      else $error("undefined glyph changed the point or drew");
   a_glyph_advance: assert property (@(posedge core_clk) disable iff (!nrst)
      state == ST_GLYPH && glyph_present |=>
      draw_valid && pos_x == 8'(draw.x + $past(glyph_width) + $past(metrics.hgap)))
      else $error("advance is not width plus gap");
   a_draw_held: assert property (@(posedge core_clk) disable iff (!nrst)
      draw_valid && !draw_ready |=> draw_valid && $stable(draw))
      else $error("draw dropped before taken");
   a_pixel_position: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_exec(CMD_PIXEL_POS) |=> pos_x == $past(prm[0]) && pos_y == $past(prm[1]))
      else $error("pixel position not applied");
   a_home_margins: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_exec(CMD_HOME) |=> pos_x == metrics.left && pos_y == metrics.top)
      else $error("home ignored margins");
   a_scroll_toggle: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_exec(CMD_SCROLL_ON) |=> auto_scroll && state == ST_IDLE)
      else $error("scroll on not taken");
   a_metrics_order: assert property (@(posedge core_clk) disable iff (!nrst)
      seq_exec(CMD_METRICS) |=> metrics.left == $past(prm[0]) && metrics.scroll_row == $past(prm[4]))
      else $error("metrics stored out of order");
   a_stored_lsb_top: assert property (@(posedge core_clk) disable iff (!nrst)
      bmp_left == 4'd8 && bmp_mode && !bmp_start |=> pix_valid && pix.on == $past(bmp_sh[0]))
      else $error("stored bitmap not LSB first");
   a_bresp_held: assert property (@(posedge core_clk) disable iff (!nrst)
      s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write response dropped");
endmodule // text_placement_engine

// *** verif/glyph_draw_model.sv ***
// partner model: glyph store and drawing unit beside the text placement engine
// assumes one clock; glyph answers are combinational from glyph_code
`timescale 1ns/100ps
module glyph_draw_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic slow,
   input wire logic [7:0] glyph_code,
   input wire logic draw_valid,
   output logic glyph_present,
   output logic [7:0] glyph_width,
   output logic [7:0] glyph_height,
   output logic [7:0] glyph_widest,
   output logic draw_ready
);
   logic [1:0] wait_cnt;
   // printable ascii only, so the top half gives undefined glyphs
   assign glyph_present = glyph_code >= 8'h20 && glyph_code <= 8'h7e;
   assign glyph_width = 8'h05;
   assign glyph_height = 8'h08;
   assign glyph_widest = 8'h06;
   // one ready pulse per draw; slow holds it off three cycles to stress the stall path
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wait_cnt <= 2'h0;
         draw_ready <= 1'b0;
      end else begin
         wait_cnt <= (draw_valid && !draw_ready) ? wait_cnt + 2'h1 : 2'h0;
         draw_ready <= draw_valid && !draw_ready && (!slow || wait_cnt == 2'h3);
      end
   end
endmodule // glyph_draw_model

// *** verif/tb.sv ***
// testbench: byte stream, register bus and bitmap stimulus for the text placement engine
// assumes the glyph_draw_model partner: glyphs 5 wide, 8 high, widest 6
`timescale 1ns/100ps
module tb;
   import text_placement_pkg::*;
   logic core_clk = 0, nrst = 0, rx_valid = 0, rx_ready, glyph_present, draw_valid, draw_ready, scroll_valid;
   logic bmp_start = 0, bmp_stored = 0, bmp_valid = 0, bmp_ready, pix_valid, slow = 0, saw_scroll = 0;
   logic s_awvalid = 0, s_wvalid = 0, s_bvalid, s_bready = 0, s_arvalid = 0, s_rvalid, s_rready = 0;
   logic s_awready, s_wready, s_arready;
   logic [7:0] rx_data = 0, glyph_code, glyph_set_index, glyph_width, glyph_height, glyph_widest, scroll_lines;
   logic [7:0] bmp_x0 = 0, bmp_y0 = 0, bmp_height = 0, bmp_width = 0, bmp_byte = 0, s_awaddr = 0, s_araddr = 0, x, y;
   logic [31:0] s_wdata = 0, s_rdata, seed = 32'h57, rd;
   logic [3:0] s_wstrb = 0;
   logic [1:0] s_bresp, s_rresp, rr;
   draw_t draw, last_draw;
   pixel_t pix;
   pixel_t pq[$];
   int fail_count = 0, n_tests = 0;
   text_placement_engine #(.SCREEN_W(240)) i_text_placement_engine (.core_clk, .nrst, .rx_valid, .rx_data,
      .rx_ready, .glyph_code, .glyph_set_index, .glyph_present, .glyph_width, .glyph_height, .glyph_widest,
      .draw_valid, .draw, .draw_ready, .scroll_valid, .scroll_lines, .bmp_start, .bmp_stored, .bmp_x0, .bmp_y0,
      .bmp_height, .bmp_width, .bmp_valid, .bmp_byte, .bmp_ready, .pix_valid, .pix, .s_awaddr, .s_awvalid,
      .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
   glyph_draw_model i_glyph_draw_model (.core_clk, .nrst, .slow, .glyph_code, .draw_valid, .glyph_present,
      .glyph_width, .glyph_height, .glyph_widest, .draw_ready);
   always #4 core_clk = ~core_clk;
   // ----------------------------------------------------------------
   // monitors and helpers
   // ----------------------------------------------------------------
   // keep the last accepted draw and every pixel for later comparison
   always @(posedge core_clk) begin
      if (draw_valid && draw_ready) begin
         last_draw <= draw;
         saw_scroll <= scroll_valid;
      end
      if (pix_valid) pq.push_back(pix);
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // stored: down the column, then next column; inline: across the row, then next row
   function automatic pixel_t exp_pix(logic st, logic [7:0] h, logic [7:0] w, int k, logic [7:0] b);
      if (st) return '{8'h0a + 8'(k / h), 8'h14 + 8'(k % h), b[k]};
      return '{8'h0a + 8'(k % w), 8'h14 + 8'(k / w), b[7-k]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // byte held until taken; valid stays up between bytes of one command
   task automatic put(input logic [7:0] b);
      rx_valid <= 1'b1;
      rx_data <= b;
      do @(posedge core_clk); while (!rx_ready);
   endtask
   task automatic idle();
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      repeat (3) @(posedge core_clk);
      while (!rx_ready) @(posedge core_clk);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [39:0] p, input int n);
      put(CMD_PREFIX);
      put(c);
      for (int i = n - 1; i >= 0; i--) put(p[8*i+:8]);
      idle();
   endtask
   task automatic text(input logic [7:0] ch);
      put(ch);
      idle();
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} <= {a, 1'b1, d, 4'hf, 1'b1, 1'b1};
      do begin
         @(posedge core_clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      rr = s_bresp;
      s_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge core_clk);
      {s_araddr, s_arvalid, s_rready} <= {a, 1'b1, 1'b1};
      do begin
         @(posedge core_clk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      rd = s_rdata;
      rr = s_rresp;
      s_rready <= 1'b0;
   endtask
   task automatic pos(input logic [7:0] px, input logic [7:0] py);
      axr(REG_POS);
      chk("point", {py, px}, rd[15:0]);
   endtask
   // one byte through the unpacker, eight pixels back
   task automatic bmp(input logic st, input logic [7:0] h, input logic [7:0] w);
      logic [7:0] b;
      b = 8'(xs());
      {bmp_stored, bmp_x0, bmp_y0, bmp_height, bmp_width, bmp_start} <= {st, 8'h0a, 8'h14, h, w, 1'b1};
      @(posedge core_clk);
      {bmp_start, bmp_valid, bmp_byte} <= {1'b0, 1'b1, b};
      pq.delete();
      do @(posedge core_clk); while (!bmp_ready);
      {bmp_valid, bmp_byte} <= {1'b0, ~b};
      repeat (12) @(posedge core_clk);
      chk("pixel count", 8, pq.size());
      for (int k = 0; k < 8 && k < pq.size(); k++) chk("pixel", exp_pix(st, h, w, k, b), pq[k]);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      chk("glyph set", RST_GLYPH_SET, glyph_set_index);
      axr(REG_SCROLL);
      chk("scroll row", 8'h40, rd[7:0]);
      axr(8'h40);
      chk("unmapped resp", 32'(RESP_SLVERR), 32'(rr));
      chk("unmapped data", 32'h0, rd);
      // random points, drawing unit prompt or slow as the seed's low bit picks
      repeat (4) begin
         x = 8'(xs() % 200);
         y = 8'(xs() % 40);
         slow <= seed[0];
         cmd(CMD_PIXEL_POS, {x, y}, 2);
         pos(x, y);
         text(8'h41);
         chk("draw", {x, y, 8'h41, 8'h01}, last_draw);
         pos(x + 8'h06, y);
         text(8'h80);
         pos(x + 8'h06, y);
      end
      cmd(CMD_METRICS, 40'h0302020128, 5);
      axr(REG_METRICS);
      chk("metrics", 32'h03020201, rd);
      cmd(CMD_HOME, 0, 0);
      pos(8'h03, 8'h02);
      cmd(CMD_CELL_POS, {8'h03, 8'h02}, 2);
      pos(8'h12, 8'h18);
      cmd(CMD_GLYPH_SET, 8'h07, 1);
      chk("glyph set", 8'h07, glyph_set_index);
      pos(8'h12, 8'h18);
      axw(REG_GLYPH_SET, 32'h1);
      chk("glyph set", 8'h01, glyph_set_index);
      chk("bresp", 32'(RESP_OKAY), 32'(rr));
      // right edge forces a new row, which lands past scroll row 40
      cmd(CMD_SCROLL_OFF, 0, 0);
      cmd(CMD_PIXEL_POS, {8'hec, 8'h1e}, 2);
      text(8'h42);
      chk("wrap draw", 16'h0302, {last_draw.x, last_draw.y});
      chk("no scroll", 0, saw_scroll);
      cmd(CMD_SCROLL_ON, 0, 0);
      cmd(CMD_PIXEL_POS, {8'hec, 8'h1e}, 2);
      text(8'h42);
      chk("scroll", 1, saw_scroll);
      chk("scroll draw", 16'h031e, {last_draw.x, last_draw.y});
      chk("scroll lines", 8'h09, scroll_lines);
      axw(REG_CTRL, 32'h0);
      axr(REG_CTRL);
      chk("ctrl", 32'h0, rd);
      bmp(1'b1, 8'h03, 8'h00);
      bmp(1'b1, 8'h08, 8'h00);
      bmp(1'b0, 8'h00, 8'h05);
      bmp(1'b0, 8'h00, 8'h08);
      tally_and_finish();
   end
   // watchdog: whole sequence needs a few hundred cycles, allow 20000
   initial begin
      #160000;
      fail_count++;
      tally_and_finish();
   end
endmodule // tb
